// >>> tldc_pkg.sv
package tldc_pkg;

	// ********************************************************************
	// Table geometry and code scale
	// ********************************************************************
	localparam int TLDC_CODE_W = 12;
	localparam int TLDC_INC_W = 4;
	localparam int TLDC_N_INC = 39;
	localparam int TLDC_IDX_W = 6;
	localparam int TLDC_REF_IDX = 13;
	localparam int TLDC_STEP_DEGC = 4;
	localparam int TLDC_MIN_DEGC = -28;
	localparam int TLDC_MAX_DEGC = 128;
	localparam int TLDC_FULL_SCALE = 4096;
	localparam int TLDC_SPAN_VOLT = 5;
	localparam int TLDC_N_CH = 2;
	localparam int TLDC_TEMP_W = 9;

	// ********************************************************************
	// Write target selectors and factory values
	// ********************************************************************
	localparam logic [1:0] TLDC_SEL_INC = 2'h0;
	localparam logic [1:0] TLDC_SEL_REF = 2'h1;
	localparam logic [1:0] TLDC_SEL_MODE = 2'h2;
	localparam logic [11:0] TLDC_REF_RST = 12'h000;
	localparam logic [3:0] TLDC_INC_RST = 4'h0;

	typedef logic [TLDC_CODE_W-1:0] tldc_code_t;
	typedef logic [TLDC_INC_W-1:0] tldc_inc_t;

	// Per-channel settings
	typedef struct packed {
		logic table_bypass;
		logic slope_polarity;
		tldc_code_t reference_code;
	} tldc_chan_cfg_s;

	// Coefficient write request
	typedef struct packed {
		logic valid;
		logic chan;
		logic [1:0] sel;
		logic [TLDC_IDX_W-1:0] index;
		tldc_code_t data;
	} tldc_wr_s;

	// Sequencer states
	typedef enum logic [3:0] {
		TLDC_ST_LOAD = 4'b0001,
		TLDC_ST_WAIT = 4'b0010,
		TLDC_ST_ACC = 4'b0100,
		TLDC_ST_DONE = 4'b1000
	} tldc_state_e;

endpackage : tldc_pkg

// >>> tldc_inc_mem.sv
`timescale 1ns/10ps
`default_nettype none

// ********************************************************************
// Increment table: two ports, registered read data
// ********************************************************************
module tldc_inc_mem #(
	parameter int DEPTH = tldc_pkg::TLDC_N_INC,
	parameter int AW = tldc_pkg::TLDC_IDX_W,
	parameter int DW = tldc_pkg::TLDC_INC_W
) (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);
	import tldc_pkg::*;

	logic [DW-1:0] mem_q [DEPTH];
	logic [DW-1:0] rdata_q;

	// Refuse a depth that the address port cannot reach
	if (DEPTH > (1 << AW)) begin : g_bad_depth
		$error("tldc_inc_mem depth exceeds address range");
	end

	// Write port and registered read port
	always_ff @(posedge clk_i) begin
		if (we_i && (int'(waddr_i) < DEPTH)) begin
			mem_q[waddr_i] <= wdata_i;
		end
		if (int'(raddr_i) < DEPTH) begin
			rdata_q <= mem_q[raddr_i];
		end else begin
			rdata_q <= '0;
		end
	end

	assign rdata_o = rdata_q;

endmodule : tldc_inc_mem

`default_nettype wire

// >>> tldc_core.sv
// Notes on behaviour
// - Curve sampled every 4 C, increments stored
// - Thirty-nine increments spanning -28 to 128 C
// - Reference code is output at 24 C
// - Code scale is 4096 steps over 5 V
// - Increments are unsigned four-bit values
// - Polarity zero rises, one falls with temperature
// - Bypass drives reference code directly
// - Coefficient writes only at upper access level
// - Writes affect output computation immediately
// - Operating memory volatile; commit copies to storage
// - Two fully independent coefficient sets
// - Factory contents all zero, output zero
// - Copy nonvolatile table before first computation
`timescale 1ns/10ps
`default_nettype none

module tldc_core (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic upper_access_level_i,
	input var tldc_pkg::tldc_wr_s wr_i,
	input wire logic commit_to_nvm_i,
	input wire logic signed [tldc_pkg::TLDC_TEMP_W-1:0] temp_degc_i,
	input wire logic temp_valid_i,
	input wire logic [tldc_pkg::TLDC_CODE_W-1:0] nvm_rdata_i,
	output logic [tldc_pkg::TLDC_IDX_W+1:0] nvm_addr_o,
	output logic nvm_wr_o,
	output logic [tldc_pkg::TLDC_CODE_W-1:0] nvm_wdata_o,
	output logic loading_o,
	output logic wr_refused_o,
	output logic [tldc_pkg::TLDC_CODE_W-1:0] converter_channel0_o,
	output logic [tldc_pkg::TLDC_CODE_W-1:0] converter_channel1_o
);
	import tldc_pkg::*;

	localparam int NVM_WORDS = TLDC_N_INC + 2;
	localparam logic [TLDC_IDX_W-1:0] LAST_IDX = 6'(TLDC_N_INC - 1);
	localparam logic [TLDC_IDX_W-1:0] REF_IDX = 6'(TLDC_REF_IDX);

	// Nonvolatile map per channel: word 0..38 increments, 39 ref, 40 mode
	function automatic logic [TLDC_IDX_W+1:0] nvm_word(input logic ch,
			input logic [TLDC_IDX_W-1:0] w);
		nvm_word = {1'b0, ch, w};
	endfunction : nvm_word

	// Interval index containing temperature (clamped to table)
	function automatic logic [TLDC_IDX_W-1:0] temp_to_idx(
			input logic signed [TLDC_TEMP_W-1:0] t);
		int v;
		v = (int'(t) - TLDC_MIN_DEGC) / TLDC_STEP_DEGC;
		if (v < 0) v = 0;
		if (v > TLDC_N_INC) v = TLDC_N_INC;
		temp_to_idx = 6'(v);
	endfunction : temp_to_idx

	// ********************************************************************
	// Volatile settings and increment tables
	// ********************************************************************
	tldc_chan_cfg_s cfg_q [TLDC_N_CH];
	tldc_chan_cfg_s cfg_d [TLDC_N_CH];
	tldc_state_e st_q, st_d;
	logic [TLDC_IDX_W-1:0] ld_q, ld_d;
	logic ld_ch_q, ld_ch_d;
	logic [TLDC_IDX_W-1:0] pt_q, pt_d;
	logic ch_q, ch_d;
	logic signed [TLDC_CODE_W+2:0] acc_q, acc_d;
	logic [TLDC_IDX_W-1:0] tgt_q, tgt_d;
	logic [TLDC_CODE_W-1:0] out_q [TLDC_N_CH];
	logic [TLDC_CODE_W-1:0] out_d [TLDC_N_CH];
	logic [TLDC_IDX_W-1:0] cm_q, cm_d;
	logic cm_ch_q, cm_ch_d, cm_act_q, cm_act_d;
	logic wr_ok, host_we;
	logic [TLDC_INC_W-1:0] inc_rd [TLDC_N_CH];
	logic [TLDC_IDX_W-1:0] mem_ra;
	logic mem_we [TLDC_N_CH];
	logic [TLDC_IDX_W-1:0] mem_wa;
	logic [TLDC_INC_W-1:0] mem_wd;
	logic temp_seen_q, temp_seen_d;
	logic ld_prime_q, ld_prime_d;
	logic ra_pt_q, ra_pt_d;

	// Writes accepted only at the upper level and after the initial copy
	assign wr_ok = wr_i.valid && upper_access_level_i && (st_q != TLDC_ST_LOAD);
	assign wr_refused_o = wr_i.valid && !wr_ok;
	assign host_we = wr_ok && (wr_i.sel == TLDC_SEL_INC);
	assign loading_o = (st_q == TLDC_ST_LOAD);

	// Memory write mux: loader during boot, host otherwise
	always_comb begin
		mem_wa = loading_o ? ld_q : wr_i.index;
		mem_wd = loading_o ? nvm_rdata_i[TLDC_INC_W-1:0] : wr_i.data[TLDC_INC_W-1:0];
		for (int c = 0; c < TLDC_N_CH; c++) begin
			mem_we[c] = loading_o ? (ld_prime_q && ld_ch_q == c[0]
				&& ld_q <= LAST_IDX)
				: (host_we && wr_i.chan == c[0]);
		end
		mem_ra = cm_act_q ? cm_q : pt_d;
	end

	// One unsigned four-bit table per channel
	for (genvar g = 0; g < TLDC_N_CH; g++) begin : g_tab
		tldc_inc_mem #(
			.DEPTH(TLDC_N_INC),
			.AW(TLDC_IDX_W),
			.DW(TLDC_INC_W)
		) u_mem (
			.clk_i(clk_i),
			.we_i(mem_we[g]),
			.waddr_i(mem_wa),
			.wdata_i(mem_wd),
			.raddr_i(mem_ra),
			.rdata_o(inc_rd[g])
		);
	end

	// ********************************************************************
	// Sequencer: boot copy, then repeated accumulation
	// ********************************************************************
	always_comb begin
		st_d = st_q;
		ld_d = ld_q;
		ld_ch_d = ld_ch_q;
		pt_d = pt_q;
		ch_d = ch_q;
		acc_d = acc_q;
		tgt_d = tgt_q;
		temp_seen_d = temp_seen_q | temp_valid_i;
		ld_prime_d = ld_prime_q;
		for (int c = 0; c < TLDC_N_CH; c++) begin
			cfg_d[c] = cfg_q[c];
			out_d[c] = out_q[c];
		end
		// Host writes land in operating memory at once
		if (wr_ok && wr_i.sel == TLDC_SEL_REF) begin
			cfg_d[wr_i.chan].reference_code = wr_i.data;
		end
		if (wr_ok && wr_i.sel == TLDC_SEL_MODE) begin
			cfg_d[wr_i.chan].table_bypass = wr_i.data[1];
			cfg_d[wr_i.chan].slope_polarity = wr_i.data[0];
		end
		case (st_q)
			TLDC_ST_LOAD: begin
				// First cycle only issues word 0; data then trails address
				if (!ld_prime_q) begin
					ld_prime_d = 1'b1;
				end else begin
				if (ld_q == 6'(TLDC_N_INC)) begin
					cfg_d[ld_ch_q].reference_code = nvm_rdata_i;
				end else if (ld_q == 6'(TLDC_N_INC + 1)) begin
					cfg_d[ld_ch_q].table_bypass = nvm_rdata_i[1];
					cfg_d[ld_ch_q].slope_polarity = nvm_rdata_i[0];
				end
				if (ld_q == 6'(NVM_WORDS - 1)) begin
					ld_d = '0;
					ld_ch_d = 1'b1;
					if (ld_ch_q) begin
						st_d = TLDC_ST_WAIT;
					end
				end else begin
					ld_d = ld_q + 6'h01;
				end
				end
			end
			TLDC_ST_WAIT: begin
				if (temp_seen_q) begin
					tgt_d = temp_to_idx(temp_degc_i);
					acc_d = '0;
					pt_d = (tgt_d >= REF_IDX) ? REF_IDX : tgt_d;
					st_d = TLDC_ST_ACC;
				end
			end
			TLDC_ST_ACC: begin
				// Read data matches pt_q unless the last read served commit
				if (pt_q >= ((tgt_q >= REF_IDX) ? tgt_q : REF_IDX)) begin
					st_d = TLDC_ST_DONE;
				end else if (ra_pt_q) begin
					acc_d = acc_q + 15'(inc_rd[ch_q]);
					pt_d = pt_q + 6'h01;
				end
			end
			default: begin
				// Apply polarity and bypass, clamp into code range
				begin
					logic signed [TLDC_CODE_W+2:0] mag, res;
					mag = (tgt_q >= REF_IDX) ? acc_q : -acc_q;
					res = 15'(cfg_q[ch_q].reference_code)
						+ (cfg_q[ch_q].slope_polarity ? -mag : mag);
					if (res < 0) res = '0;
					if (res > 15'(TLDC_FULL_SCALE - 1)) res = 15'(TLDC_FULL_SCALE - 1);
					out_d[ch_q] = cfg_q[ch_q].table_bypass
						? cfg_q[ch_q].reference_code : res[TLDC_CODE_W-1:0];
				end
				ch_d = ~ch_q;
				st_d = TLDC_ST_WAIT;
			end
		endcase
	end

	// Sequencer registers; table address leads pt_q by one cycle
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_q <= TLDC_ST_LOAD;
			ld_q <= '0;
			ld_ch_q <= 1'b0;
			pt_q <= '0;
			ch_q <= 1'b0;
			acc_q <= '0;
			tgt_q <= '0;
			temp_seen_q <= 1'b0;
			ld_prime_q <= 1'b0;
			for (int c = 0; c < TLDC_N_CH; c++) begin
				cfg_q[c] <= '{1'b0, 1'b0, TLDC_REF_RST};
				out_q[c] <= TLDC_REF_RST;
			end
		end else begin
			st_q <= st_d;
			ld_q <= ld_d;
			ld_ch_q <= ld_ch_d;
			pt_q <= pt_d;
			ch_q <= ch_d;
			acc_q <= acc_d;
			tgt_q <= tgt_d;
			temp_seen_q <= temp_seen_d;
			ld_prime_q <= ld_prime_d;
			for (int c = 0; c < TLDC_N_CH; c++) begin
				cfg_q[c] <= cfg_d[c];
				out_q[c] <= out_d[c];
			end
		end
	end

	// ********************************************************************
	// Commit engine: copies operating memory to nonvolatile storage
	// ********************************************************************
	always_comb begin
		cm_d = cm_q;
		cm_ch_d = cm_ch_q;
		cm_act_d = cm_act_q;
		ra_pt_d = !cm_act_q;
		nvm_wr_o = 1'b0;
		nvm_wdata_o = '0;
		nvm_addr_o = loading_o ? nvm_word(ld_ch_d, ld_d) : nvm_word(cm_ch_q, cm_q);
		if (!cm_act_q) begin
			if (commit_to_nvm_i && !loading_o) begin
				cm_act_d = 1'b1;
				cm_d = '0;
				cm_ch_d = 1'b0;
			end
		end else begin
			// Increment words wait one cycle for registered read data
			nvm_wr_o = 1'b1;
			nvm_addr_o = nvm_word(cm_ch_q, cm_q - 6'h01);
			if (cm_q == 6'h00) begin
				nvm_wr_o = 1'b0;
			end else if (cm_q <= 6'(TLDC_N_INC)) begin
				nvm_wdata_o = 12'(inc_rd[cm_ch_q]);
			end else if (cm_q == 6'(TLDC_N_INC + 1)) begin
				nvm_wdata_o = cfg_q[cm_ch_q].reference_code;
			end else begin
				nvm_wdata_o = {10'h000, cfg_q[cm_ch_q].table_bypass,
					cfg_q[cm_ch_q].slope_polarity};
			end
			if (cm_q == 6'(NVM_WORDS)) begin
				cm_d = '0;
				cm_ch_d = 1'b1;
				cm_act_d = !cm_ch_q;
			end else begin
				cm_d = cm_q + 6'h01;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cm_q <= '0;
			cm_ch_q <= 1'b0;
			cm_act_q <= 1'b0;
			ra_pt_q <= 1'b0;
		end else begin
			cm_q <= cm_d;
			cm_ch_q <= cm_ch_d;
			cm_act_q <= cm_act_d;
			ra_pt_q <= ra_pt_d;
		end
	end

	assign converter_channel0_o = out_q[0];
	assign converter_channel1_o = out_q[1];

	// ********************************************************************
	// Checks
	// ********************************************************************
	property p_bypass_ref;
		@(posedge clk_i) disable iff (!rstn_i)
		(st_q == TLDC_ST_DONE && cfg_q[0].table_bypass && !ch_q
			&& !(wr_ok && !wr_i.chan))
		|=> converter_channel0_o == $past(cfg_q[0].reference_code);
	endproperty
	a_bypass_ref: assert property (p_bypass_ref)
		else $error("bypass did not drive reference code");

	property p_refuse_low;
		@(posedge clk_i) disable iff (!rstn_i)
		(wr_i.valid && !upper_access_level_i) |-> wr_refused_o && !host_we;
	endproperty
	a_refuse_low: assert property (p_refuse_low)
		else $error("write accepted below upper level");

	property p_ref_now;
		@(posedge clk_i) disable iff (!rstn_i)
		(wr_ok && wr_i.sel == TLDC_SEL_REF && !wr_i.chan && !loading_o)
		|=> cfg_q[0].reference_code == $past(wr_i.data);
	endproperty
	a_ref_now: assert property (p_ref_now)
		else $error("reference write not applied");

	property p_boot_zero;
		@(posedge clk_i) disable iff (!rstn_i)
		loading_o |-> converter_channel0_o == 12'h000 && converter_channel1_o == 12'h000;
	endproperty
	a_boot_zero: assert property (p_boot_zero)
		else $error("output moved before table copy");

	property p_load_len;
		@(posedge clk_i) disable iff (!rstn_i)
		$rose(ld_ch_q) |-> ##40 loading_o ##1 !loading_o;
	endproperty
	a_load_len: assert property (p_load_len)
		else $error("boot copy did not finish in time");

	property p_commit_wr;
		@(posedge clk_i) disable iff (!rstn_i)
		(commit_to_nvm_i && !cm_act_q && !loading_o) |=> ##1 nvm_wr_o [*8];
	endproperty
	a_commit_wr: assert property (p_commit_wr)
		else $error("commit did not write storage");

	property p_range;
		@(posedge clk_i) disable iff (!rstn_i)
		st_q == TLDC_ST_ACC |-> pt_q <= 6'(TLDC_N_INC);
	endproperty
	a_range: assert property (p_range)
		else $error("accumulator walked past table");

	property p_chan_sep;
		@(posedge clk_i) disable iff (!rstn_i)
		(wr_ok && wr_i.chan && st_q == TLDC_ST_WAIT)
		|=> $stable(cfg_q[0]);
	endproperty
	a_chan_sep: assert property (p_chan_sep)
		else $error("channel one write touched channel zero");

	c_commit: cover property (@(posedge clk_i) disable iff (!rstn_i)
		commit_to_nvm_i && !cm_act_q && !loading_o);
	c_fall: cover property (@(posedge clk_i) disable iff (!rstn_i)
		st_q == TLDC_ST_DONE && cfg_q[ch_q].slope_polarity);
	c_cold: cover property (@(posedge clk_i) disable iff (!rstn_i)
		st_q == TLDC_ST_DONE && tgt_q < REF_IDX);

endmodule : tldc_core

`default_nettype wire

// >>> tldc_core_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tldc_core_tb_top;
	import tldc_pkg::*;

	// ****************************************************************
	// Stimulus, nonvolatile store and reference model state
	// ****************************************************************
	logic clk_i = 1'b0;
	logic rstn_i = 1'b1;
	logic upper_access_level = 1'b1;
	tldc_wr_s wr = '0;
	logic commit = 1'b0;
	logic signed [TLDC_TEMP_W-1:0] temp = 9'h01C;
	logic temp_vld = 1'b0;
	logic [TLDC_CODE_W-1:0] nvm_rd = 12'h000;
	logic [TLDC_IDX_W+1:0] nvm_addr;
	logic [TLDC_IDX_W+1:0] rd_addr_q = 8'h00;
	logic nvm_wr;
	logic loading;
	logic refused;
	logic [TLDC_CODE_W-1:0] nvm_wd;
	logic [TLDC_CODE_W-1:0] out0;
	logic [TLDC_CODE_W-1:0] out1;
	logic [TLDC_CODE_W-1:0] nvm [256];
	logic [3:0] inc_m [2][TLDC_N_INC];
	logic [11:0] rc_m [2];
	logic pol_m [2];
	logic byp_m [2];
	int error_cnt = 0;
	int n_compared = 0;
	int cyc = 0;
	int tl [10] = '{-40, -28, -25, 20, 24, 27, 60, 127, 128, 140};

	always #5 clk_i = ~clk_i;

	tldc_core u_tldc_core (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.upper_access_level_i(upper_access_level),
		.wr_i(wr),
		.commit_to_nvm_i(commit),
		.temp_degc_i(temp),
		.temp_valid_i(temp_vld),
		.nvm_rdata_i(nvm_rd),
		.nvm_addr_o(nvm_addr),
		.nvm_wr_o(nvm_wr),
		.nvm_wdata_o(nvm_wd),
		.loading_o(loading),
		.wr_refused_o(refused),
		.converter_channel0_o(out0),
		.converter_channel1_o(out1)
	);

	// Store: address taken mid-cycle, data shown one cycle later
	always @(negedge clk_i) begin
		rd_addr_q = nvm_addr;
		if (nvm_wr === 1'b1) nvm[nvm_addr] = nvm_wd;
	end
	always @(posedge clk_i) begin
		#1 nvm_rd = nvm[rd_addr_q];
	end

	// Hang guard
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			tally_and_finish();
		end
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic tally_and_finish();
		$display("Compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic cmp(input string what, input logic [11:0] e,
		input logic [11:0] got);
		n_compared++;
		if (got !== e) begin
			error_cnt++;
			$display("ERROR %s expected %0h seen %0h", what, e, got);
		end
	endtask : cmp

	// One write cycle; model follows only when acceptance is expected
	task automatic write(input int ch, input logic [1:0] s, input int idx,
		input logic [11:0] d, input logic no);
		@(posedge clk_i);
		#1;
		wr = '{valid: 1'b1, chan: ch[0], sel: s, index: idx[5:0], data: d};
		#1;
		cmp("write refused", 12'(no), 12'(refused));
		@(posedge clk_i);
		#1;
		wr.valid = 1'b0;
		if (!no) begin
			case (s)
				TLDC_SEL_INC: inc_m[ch][idx] = d[3:0];
				TLDC_SEL_REF: rc_m[ch] = d;
				default: begin
					byp_m[ch] = d[1];
					pol_m[ch] = d[0];
				end
			endcase
		end
	endtask : write

	function automatic logic [11:0] expect_code(input int ch, input int t);
		int idx;
		int acc;
		idx = (t < -28) ? 0 : (t + 28) / 4;
		if (idx > 39) idx = 39;
		acc = 0;
		for (int k = 13; k < idx; k++) acc += inc_m[ch][k];
		for (int k = idx; k < 13; k++) acc -= inc_m[ch][k];
		if (pol_m[ch]) acc = -acc;
		acc += rc_m[ch];
		if (byp_m[ch]) acc = rc_m[ch];
		if (acc < 0) acc = 0;
		if (acc > 4095) acc = 4095;
		return acc[11:0];
	endfunction : expect_code

	// Apply a temperature and wait, bounded, for the expected code
	task automatic chk(input int ch, input int t);
		logic [11:0] e;
		logic [11:0] got;
		e = expect_code(ch, t);
		temp = t[8:0];
		for (int i = 0; i < 300; i++) begin
			got = ch ? out1 : out0;
			if (got === e) break;
			@(posedge clk_i);
			#1;
		end
		cmp("converter code", e, got);
	endtask : chk

	// Wait for the boot copy, then mark the first measurement
	task automatic wait_boot();
		for (int i = 0; i < 300 && loading !== 1'b0; i++) begin
			@(posedge clk_i);
			#1;
		end
		cmp("boot copy done", 12'h000, 12'(loading));
		temp = 9'h01C;
		temp_vld = 1'b1;
		@(posedge clk_i);
		#1;
		temp_vld = 1'b0;
	endtask : wait_boot

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		for (int i = 0; i < 256; i++) nvm[i] = 12'h000;
		#1;
		rstn_i = 1'b0;
		for (int i = 0; i < TLDC_N_INC; i++) inc_m[0][i] = 4'h0;
		inc_m[1] = inc_m[0];
		rc_m = '{12'h064, 12'h000};
		pol_m = '{1'b0, 1'b0};
		byp_m = '{1'b0, 1'b0};
		nvm[39] = 12'h064;
		nvm[13] = 12'h005;
		inc_m[0][13] = 4'h5;
		repeat (8) @(posedge clk_i);
		#1;
		cmp("code in reset", 12'h000, out0);
		cmp("loading in reset", 12'h001, 12'(loading));
		rstn_i = 1'b1;
		write(0, TLDC_SEL_REF, 0, 12'h123, 1'b1);
		wait_boot();
		chk(0, 28);
		chk(1, 28);
		upper_access_level = 1'b0;
		write(0, TLDC_SEL_REF, 0, 12'h7FF, 1'b1);
		chk(0, 28);
		upper_access_level = 1'b1;
		write(0, TLDC_SEL_REF, 0, 12'h747, 1'b0);
		chk(0, 24);
		for (int k = 0; k < TLDC_N_INC; k++) begin
			write(0, TLDC_SEL_INC, k, {8'hF0, 4'(k % 16)}, 1'b0);
		end
		foreach (tl[i]) chk(0, tl[i]);
		write(0, TLDC_SEL_MODE, 0, 12'h001, 1'b0);
		chk(0, 128);
		chk(0, -28);
		write(0, TLDC_SEL_REF, 0, 12'hFF0, 1'b0);
		chk(0, -28);
		write(0, TLDC_SEL_MODE, 0, 12'h003, 1'b0);
		chk(0, 128);
		write(1, TLDC_SEL_REF, 0, 12'h414, 1'b0);
		write(1, TLDC_SEL_INC, 20, 12'h009, 1'b0);
		chk(1, 128);
		chk(1, -28);
		chk(0, 128);
		commit = 1'b1;
		@(posedge clk_i);
		#1;
		commit = 1'b0;
		for (int i = 0; i < 600 && nvm[103] !== 12'h414; i++) begin
			@(posedge clk_i);
			#1;
		end
		repeat (10) @(posedge clk_i);
		#1;
		cmp("stored ref ch0", 12'hFF0, nvm[39]);
		cmp("stored mode ch0", 12'h003, nvm[40]);
		cmp("stored inc ch0", 12'h00F, nvm[15]);
		cmp("stored inc ch1", 12'h009, nvm[84]);
		rstn_i = 1'b0;
		repeat (8) @(posedge clk_i);
		#1;
		rstn_i = 1'b1;
		wait_boot();
		chk(1, 128);
		chk(0, 60);
		tally_and_finish();
	end

endmodule : tldc_core_tb_top

`default_nettype wire
